/* File: core/tpc_bank.sv */
// One capture bank: first slot, latest slot and tally
`timescale 1ns/1ps
module tpc_bank (
	input  wire logic                            i_clk,
	input  wire logic                            i_rst,
	input  wire logic                            i_clear,
	input  wire logic                            i_cap,
	input  wire logic [tpc_pkg::TPC_TMR_W-1:0]   i_value,
	output logic      [tpc_pkg::TPC_TMR_W-1:0]   o_first,
	output logic      [tpc_pkg::TPC_TMR_W-1:0]   o_last,
	output logic      [tpc_pkg::TPC_TALLY_W-1:0] o_tally,
	output logic                                 o_has_first
);
	import tpc_pkg::*;

	logic                   empty_w;
	logic [TPC_TALLY_W-1:0] base_w;
	logic [TPC_TALLY_W-1:0] bump_w;

	// A clear and a capture together leave exactly one capture
	assign empty_w = i_clear | ~o_has_first;
	assign base_w  = i_clear ? TPC_TALLY_RST : o_tally;
	// Tally sticks at full scale instead of wrapping to a small count
	assign bump_w  = (base_w == TPC_TALLY_MAX) ? base_w : base_w + TPC_TALLY_ONE;

	// Slot and tally registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_first     <= TPC_TMR_RST;
			o_last      <= TPC_TMR_RST;
			o_tally     <= TPC_TALLY_RST;
			o_has_first <= 1'b0;
		end else if (i_cap) begin
			if (empty_w)
				o_first <= i_value;
			o_last      <= i_value;
			o_tally     <= bump_w;
			o_has_first <= 1'b1;
		end else if (i_clear) begin
			o_first     <= TPC_TMR_RST;
			o_last      <= TPC_TMR_RST;
			o_tally     <= TPC_TALLY_RST;
			o_has_first <= 1'b0;
		end
	end

endmodule

/* File: core/tpc_fall_sync.sv */
// Two-stage synchroniser with falling-edge detector for the tacho pin
`timescale 1ns/1ps
module tpc_fall_sync (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_pin,
	output logic      o_fall
);
	import tpc_pkg::*;

	logic [2:0] sh_r;
	logic       fall_w;

	// Only the second and third stages feed the edge compare
	assign fall_w = sh_r[2] & ~sh_r[1];

	// Idle high, so a pin held low at reset release gives one falling edge
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sh_r   <= TPC_SYNC_RST;
			o_fall <= 1'b0;
		end else begin
			sh_r   <= {sh_r[1:0], i_pin};
			o_fall <= fall_w;
		end
	end

endmodule

/* File: core/tpc_pkg.sv */
// Shared constants, types and contract list for the tacho period capture block
// Contract
// - Speed is measured by timestamping falling edges of the tacho input against a timer on one capture channel.
// - Two capture banks alternate, one filling during the current period while the other is evaluated.
// - Each bank holds a first-capture slot, a latest-capture slot and a capture tally.
// - The first-capture slot keeps only the earliest capture after a timer update.
// - The latest-capture slot is overwritten on every capture.
// - The tally counts the captures taken within the current timer period.
// - Each capture stores the timer value in the proper slot of the active bank and bumps its tally.
// - Each timer update swaps the active bank and hands the filled one over for evaluation.
// - The prescaler for the next period is chosen so that the expected captures match the target count; the code steps it by one per period toward the target.
// - The span in timer counts from first to last capture of the evaluated bank is published.
// - The capture count of the evaluated bank is published.
// - The prescaler in force while those captures were taken is published with them.
package tpc_pkg;

	localparam int TPC_TMR_W   = 16;
	localparam int TPC_TALLY_W = 8;
	localparam int TPC_DIV_W   = 8;
	localparam int TPC_BANKS   = 2;

	localparam logic [TPC_TMR_W-1:0]   TPC_TMR_RST   = 16'h0000;
	localparam logic [TPC_TMR_W-1:0]   TPC_TMR_TOP   = 16'hffff;
	localparam logic [TPC_TMR_W-1:0]   TPC_TMR_ONE   = 16'h0001;
	localparam logic [TPC_TALLY_W-1:0] TPC_TALLY_RST = 8'h00;
	localparam logic [TPC_TALLY_W-1:0] TPC_TALLY_MAX = 8'hff;
	localparam logic [TPC_TALLY_W-1:0] TPC_TALLY_ONE = 8'h01;
	localparam logic [TPC_DIV_W-1:0]   TPC_DIV_RST   = 8'h00;
	localparam logic [TPC_DIV_W-1:0]   TPC_DIV_MAX   = 8'hff;
	localparam logic [TPC_DIV_W-1:0]   TPC_DIV_ONE   = 8'h01;
	localparam logic [TPC_DIV_W-1:0]   TPC_PRE_RST   = 8'h00;
	localparam logic                   TPC_BANK_RST  = 1'b0;
	localparam logic [2:0]             TPC_SYNC_RST  = 3'h7;

	// Published measurement, packed span:tally:divider from msb down
	typedef struct packed {
		logic [TPC_TMR_W-1:0]   span;
		logic [TPC_TALLY_W-1:0] tally;
		logic [TPC_DIV_W-1:0]   divider;
	} tpc_result_t;

	// Gray order along run -> eval -> adjust
	typedef enum logic [1:0] {
		TPC_ST_RUN  = 2'b00,
		TPC_ST_EVAL = 2'b01,
		TPC_ST_ADJ  = 2'b11
	} tpc_state_t;

endpackage

/* File: core/tpc_tacho_period_capture.sv */
// Tacho period capture: prescaled timer, ping-pong banks, evaluation and prescaler steering
`timescale 1ns/1ps
module tpc_tacho_period_capture (
	input  wire logic                            i_clk,
	input  wire logic                            i_rst,
	input  wire logic                            i_tacho,
	input  wire logic                            i_enable,
	input  wire logic [tpc_pkg::TPC_TALLY_W-1:0] i_target_pulses,
	output tpc_pkg::tpc_result_t                 o_result,
	output logic                                 o_result_valid,
	output logic      [tpc_pkg::TPC_DIV_W-1:0]   o_timer_divider_setting,
	output logic      [tpc_pkg::TPC_TMR_W-1:0]   o_timer,
	output logic                                 o_active_bank,
	output logic      [tpc_pkg::TPC_TALLY_W-1:0] o_bank_zero_tally,
	output logic      [tpc_pkg::TPC_TALLY_W-1:0] o_bank_one_tally
);
	import tpc_pkg::*;

	// Cycle walk around one timer wrap, U being the update cycle:
	//   U    timer at full scale ticks, update strobe high
	//   U+1  selector flipped, fresh bank cleared, sequencer in eval
	//   U+2  result word and valid pulse out, sequencer in adjust
	//   U+3  divider stepped, valid low again
	// The handed-over bank is frozen from U+1 on, so the eval
	// cycle reads it directly instead of through a shadow copy.
	// A tacho edge needs three clocks to reach a bank: two
	// synchroniser stages and the edge flop. Limitation: pin
	// levels shorter than one clock may be lost altogether.
	// Captures stamp the timer as it stood when the edge
	// flag was raised; stamps within one bank share a
	// divider, so their difference is a clean span.
	// Steering moves the divider by one step per period, so
	// a large speed change takes several periods to settle;
	// the trade buys immunity to a single noisy period.
	// Stopping the block clears the timer but not the banks.

	// Prescaler and timer
	logic [TPC_DIV_W-1:0]   pre_r;
	logic [TPC_DIV_W-1:0]   pre_nxt;
	logic [TPC_DIV_W-1:0]   pre_inc_w;
	logic [TPC_TMR_W-1:0]   tmr_inc_w;
	logic [TPC_TMR_W-1:0]   tmr_r;
	logic [TPC_TMR_W-1:0]   tmr_nxt;
	logic [TPC_DIV_W-1:0]   div_r;
	logic [TPC_DIV_W-1:0]   div_nxt;
	logic [TPC_DIV_W-1:0]   div_used_r;
	logic                   tick_w;
	logic                   upd_w;

	// Capture path, from the pin edge flag to the bank
	// that takes the stamp
	logic                   fall_w;
	logic                   cap_w;
	logic [TPC_TMR_W-1:0]   cap_val_w;
	logic                   sel_r;
	logic                   dest_w;

	// Bank buses, one lane per bank, indexed by the
	// selector value that makes that bank active
	logic [TPC_BANKS-1:0]   clr_w;
	logic [TPC_BANKS-1:0]   bcap_w;
	logic [TPC_TMR_W-1:0]   first_w [TPC_BANKS];
	logic [TPC_TMR_W-1:0]   last_w  [TPC_BANKS];
	logic [TPC_TALLY_W-1:0] tally_w [TPC_BANKS];
	logic [TPC_BANKS-1:0]   has_w;

	// Evaluation, sequencing and divider steering; all of
	// it reads only the bank that was handed over
	logic                   idle_w;
	logic [TPC_TMR_W-1:0]   span_w;
	logic [TPC_TALLY_W-1:0] ev_tally_w;
	tpc_result_t            res_w;
	tpc_state_t             st_r;
	tpc_state_t             st_nxt;
	logic                   more_w;
	logic                   fewer_w;
	logic                   st_eval_w;
	logic                   st_adj_w;
	logic [TPC_TMR_W-1:0]   span_raw_w;
	logic [TPC_DIV_W-1:0]   div_up_w;
	logic [TPC_DIV_W-1:0]   div_dn_w;

	// Pin edge detector, synchronised before use
	tpc_fall_sync u_sync (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_pin  (i_tacho),
		.o_fall (fall_w)
	);

	// Prescaler divides the clock by setting plus one.
	// Greater-or-equal compare: a lowered setting
	// must not let the count run past it.
	assign tick_w    = i_enable & (pre_r >= div_r);
	assign pre_inc_w = pre_r + TPC_DIV_ONE;
	assign pre_nxt   = (!i_enable || tick_w) ? TPC_PRE_RST : pre_inc_w;

	// Free-running timer, wraps at full scale
	assign tmr_inc_w = tmr_r + TPC_TMR_ONE;
	assign tmr_nxt   = !i_enable ? TPC_TMR_RST
		: tick_w ? tmr_inc_w : tmr_r;

	// Update event on the wrap tick; it lasts one clock
	// whatever the divider, as the prescaler restarts at once
	assign upd_w = tick_w & (tmr_r == TPC_TMR_TOP);

	// Prescaler count register
	always_ff @(posedge i_clk) begin
		if (i_rst)
			pre_r <= TPC_PRE_RST;
		else
			pre_r <= pre_nxt;
	end

	// Timer register; stopping the block restarts it at zero
	always_ff @(posedge i_clk) begin
		if (i_rst)
			tmr_r <= TPC_TMR_RST;
		else
			tmr_r <= tmr_nxt;
	end

	// Captures only count while the timer runs; an edge
	// seen while stopped is dropped, not held back
	assign cap_w = fall_w & i_enable;

	// A capture on the update cycle belongs to the
	// new period, stamped with the wrapped value
	assign dest_w    = upd_w ? ~sel_r : sel_r;
	assign cap_val_w = upd_w ? TPC_TMR_RST : tmr_r;

	// Bank being handed over sits opposite the active one;
	// it only changes again at the next update
	assign idle_w = ~sel_r;

	// Active bank selector flips on every update
	always_ff @(posedge i_clk) begin
		if (i_rst)
			sel_r <= TPC_BANK_RST;
		else if (upd_w)
			sel_r <= ~sel_r;
	end

	// Two identical banks, steered by index
	genvar gi;
	generate
		for (gi = 0; gi < TPC_BANKS; gi++) begin : g_bank
			// One-bit index of this bank for the selector compares
			localparam logic BANK_ID = 1'(gi);

			// Fresh bank is wiped as it takes over; a capture in
			// the same cycle still lands, the bank settles the race
			assign clr_w[gi]  = upd_w & (sel_r != BANK_ID);
			assign bcap_w[gi] = cap_w & (dest_w == BANK_ID);

			tpc_bank u_bank (
				.i_clk       (i_clk),
				.i_rst       (i_rst),
				.i_clear     (clr_w[gi]),
				.i_cap       (bcap_w[gi]),
				.i_value     (cap_val_w),
				.o_first     (first_w[gi]),
				.o_last      (last_w[gi]),
				.o_tally     (tally_w[gi]),
				.o_has_first (has_w[gi])
			);
		end
	endgenerate

	// Per-bank tallies straight from the bank flops
	assign o_bank_zero_tally = tally_w[0];
	assign o_bank_one_tally  = tally_w[1];

	// Span of the handed-over bank; modulo arithmetic
	// covers one wrap, which an update always marks
	assign span_raw_w = last_w[idle_w] - first_w[idle_w];
	// An empty bank reports a zero span, not stale slots
	assign span_w     = has_w[idle_w] ? span_raw_w : TPC_TMR_RST;
	assign ev_tally_w = tally_w[idle_w];

	// Snapshot of one whole period
	assign res_w.span    = span_w;
	assign res_w.tally   = ev_tally_w;
	assign res_w.divider = div_used_r;

	// Remember which divider the ended period ran on,
	// latched before steering can touch it
	always_ff @(posedge i_clk) begin
		if (i_rst)
			div_used_r <= TPC_DIV_RST;
		else if (upd_w)
			div_used_r <= div_r;
	end

	// Sequencer: wait for update, publish, steer divider
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			TPC_ST_RUN: begin
				// Waiting out the period
				if (upd_w)
					st_nxt = TPC_ST_EVAL;
			end
			TPC_ST_EVAL: begin
				// Handed-over bank is read this cycle
				st_nxt = TPC_ST_ADJ;
			end
			TPC_ST_ADJ: begin
				// Divider steered from the same tally
				st_nxt = TPC_ST_RUN;
			end
			default: begin
				st_nxt = TPC_ST_RUN;
			end
		endcase
	end

	// Sequencer state register
	always_ff @(posedge i_clk) begin
		if (i_rst)
			st_r <= TPC_ST_RUN;
		else
			st_r <= st_nxt;
	end

	// State decodes shared by publishing and steering
	assign st_eval_w = (st_r == TPC_ST_EVAL);
	assign st_adj_w  = (st_r == TPC_ST_ADJ);

	// Valid strobe, one clock per period
	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_result_valid <= 1'b0;
		else
			o_result_valid <= st_eval_w;
	end

	// Publish all three fields in a single write
	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_result <= '0;
		else if (st_eval_w)
			o_result <= res_w;
	end

	// Pulse count scales with period length, so
	// too few pulses want a longer period (bigger
	// divider) and too many a shorter one.
	// One step per period: slow to settle but it
	// never overshoots on a single noisy period.
	assign more_w  = (ev_tally_w < i_target_pulses)
		& (div_r != TPC_DIV_MAX);
	assign fewer_w = (ev_tally_w > i_target_pulses)
		& (div_r != TPC_DIV_RST);
	// Limitation: the tally saturates at full scale, so a
	// target of full scale can never be seen as exceeded
	assign div_up_w = div_r + TPC_DIV_ONE;
	assign div_dn_w = div_r - TPC_DIV_ONE;

	// Next divider, applied only after publishing
	always_comb begin
		div_nxt = div_r;
		if (st_adj_w) begin
			if (more_w)
				div_nxt = div_up_w;
			else if (fewer_w)
				div_nxt = div_dn_w;
		end
	end

	// Divider register; change lands two cycles into
	// the new period, a negligible error
	always_ff @(posedge i_clk) begin
		if (i_rst)
			div_r <= TPC_DIV_RST;
		else
			div_r <= div_nxt;
	end

	// Divider mirror, loaded from the next value so it
	// never lags the register it copies
	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_timer_divider_setting <= TPC_DIV_RST;
		else
			o_timer_divider_setting <= div_nxt;
	end

	// Timer mirror, same count as the internal timer
	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_timer <= TPC_TMR_RST;
		else
			o_timer <= tmr_nxt;
	end

	// Active bank mirror follows the selector flip
	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_active_bank <= TPC_BANK_RST;
		else
			o_active_bank <= dest_w;
	end

endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the tacho period capture block
`timescale 1ns/1ps
module testbench;
	import tpc_pkg::*;
	logic        i_clk;
	logic        i_rst;
	logic        i_tacho;
	logic        i_enable;
	logic [7:0]  i_target_pulses;
	tpc_result_t o_result;
	logic        o_result_valid;
	logic [7:0]  o_timer_divider_setting;
	logic [15:0] o_timer;
	logic        o_active_bank;
	logic [7:0]  o_bank_zero_tally;
	logic [7:0]  o_bank_one_tally;
	logic        go;
	logic [15:0] gap;
	logic        busy;
	logic [31:0] seed = 32'h00000023;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          nf = 0;
	int          t_first, t_last, n_pulses, i;

	tpc_tacho_model tacho (.i_clk(i_clk), .i_go(go), .i_gap(gap), .o_tacho(i_tacho), .o_busy(busy));
	tpc_tacho_period_capture dut (.i_clk(i_clk), .i_rst(i_rst), .i_tacho(i_tacho), .i_enable(i_enable),
		.i_target_pulses(i_target_pulses), .o_result(o_result), .o_result_valid(o_result_valid),
		.o_timer_divider_setting(o_timer_divider_setting), .o_timer(o_timer), .o_active_bank(o_active_bank),
		.o_bank_zero_tally(o_bank_zero_tally), .o_bank_one_tally(o_bank_one_tally));

	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// Bench's own timestamps of the edges it hands over, as clock
	// edge numbers from simulation time so no update order matters
	always @(negedge i_tacho) if (i_enable === 1'b1) begin
		if (nf == 0) t_first = int'($realtime / 25.0);
		t_last = int'($realtime / 25.0);
		nf++;
	end

	function logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	// One steering step per period
	function logic [15:0] next_div(input int d, input int t, input int g);
		if (t < g && d < 255) return 16'(d + 1);
		if (t > g && d > 0) return 16'(d - 1);
		return 16'(d);
	endfunction

	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One pulse, then let the capture reach the tally
	task send(input logic [15:0] g);
		int k;
		k = 0;
		@(posedge i_clk);
		go <= 1'b1;
		gap <= g;
		@(posedge i_clk);
		go <= 1'b0;
		do begin
			@(posedge i_clk);
			#1;
		end while (busy && ++k < 4000);
		repeat (4) @(posedge i_clk);
		#1;
	endtask
	task results;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge i_clk);
		n_fail++;
		results;
	end

	initial begin
		i_rst = 1'b1;
		i_enable = 1'b0;
		i_target_pulses = 8'h00;
		go = 1'b0;
		gap = 16'h0000;
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		// Pulse while stopped is ignored
		send(16'h0002);
		chk(16'(o_bank_zero_tally), 16'h0000);
		chk(o_timer, 16'h0000);
		seed = xs(seed);
		i_target_pulses <= {4'h0, seed[3:0]};
		n_pulses = 5 + int'(seed[10:8]);
		@(posedge i_clk);
		i_enable <= 1'b1;
		// First pulse at the shortest spacing, rest random
		for (int p = 0; p < n_pulses; p++) begin
			seed = xs(seed);
			send(p == 0 ? 16'h0002 : {5'h00, seed[10:0]} + 16'h0002);
			chk(16'(o_bank_zero_tally), 16'(p + 1));
		end
		for (i = 0; i < 70000 && o_result_valid !== 1'b1; i++) begin
			@(posedge i_clk);
			#1;
		end
		chk(16'(o_result_valid), 16'h0001);
		chk(o_result.span, 16'(t_last - t_first));
		chk(16'(o_result.tally), 16'(n_pulses));
		chk(16'(o_result.divider), 16'h0000);
		chk(16'(o_active_bank), 16'h0001);
		chk(16'(o_bank_one_tally), 16'h0000);
		@(posedge i_clk);
		#1;
		chk(16'(o_timer_divider_setting), next_div(0, n_pulses, int'(i_target_pulses)));
		// Next capture goes to the other bank
		send(16'h0010);
		chk(16'(o_bank_one_tally), 16'h0001);
		chk(16'(o_bank_zero_tally), 16'(n_pulses));
		results;
	end
endmodule

/* File: verification/tpc_period_sva.sv */
// Port checker for the tacho period capture block
`timescale 1ns/1ps
module tpc_period_sva (
	input wire logic                          i_clk,
	input wire logic                          i_rst,
	input wire logic                          i_enable,
	input wire tpc_pkg::tpc_result_t          o_result,
	input wire logic                          o_result_valid,
	input wire logic [tpc_pkg::TPC_DIV_W-1:0] o_timer_divider_setting,
	input wire logic [tpc_pkg::TPC_TMR_W-1:0] o_timer,
	input wire logic                          o_active_bank,
	input wire logic [tpc_pkg::TPC_TALLY_W-1:0] o_bank_zero_tally,
	input wire logic [tpc_pkg::TPC_TALLY_W-1:0] o_bank_one_tally
);
	import tpc_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Publishing and bank swap at the wrap
	result_hold_a: assert property (!o_result_valid |-> $stable(o_result)) else $error("result moved");
	valid_pulse_a: assert property (o_result_valid |=> !o_result_valid) else $error("valid too long");
	bank_swap_a: assert property ($past(i_enable) && $past(o_timer) == TPC_TMR_TOP && o_timer == TPC_TMR_RST
		|-> $changed(o_active_bank)) else $error("no swap at wrap");
	swap_publish_a: assert property ($changed(o_active_bank) |=> o_result_valid) else $error("no publish");
	new_bank_clr_a: assert property ($changed(o_active_bank)
		|-> (o_active_bank ? o_bank_one_tally : o_bank_zero_tally) <= TPC_TALLY_ONE) else $error("bank not cleared");
	// The bank under evaluation must not move
	zero_hold_a: assert property ($past(o_active_bank) && o_active_bank |-> $stable(o_bank_zero_tally))
		else $error("idle bank zero moved");
	one_hold_a: assert property (!$past(o_active_bank) && !o_active_bank |-> $stable(o_bank_one_tally))
		else $error("idle bank one moved");
	div_tag_a: assert property (o_result_valid |-> o_result.divider == o_timer_divider_setting)
		else $error("wrong divider tag");
	div_step_a: assert property ($changed(o_timer_divider_setting) |-> $past(o_result_valid))
		else $error("divider moved off period");

	cover property (o_result_valid);
	cover property ($changed(o_timer_divider_setting));
	cover property (o_bank_zero_tally == 8'h05);
endmodule

bind tpc_tacho_period_capture tpc_period_sva chk (.i_clk(i_clk), .i_rst(i_rst), .i_enable(i_enable),
	.o_result(o_result), .o_result_valid(o_result_valid), .o_timer_divider_setting(o_timer_divider_setting),
	.o_timer(o_timer), .o_active_bank(o_active_bank), .o_bank_zero_tally(o_bank_zero_tally),
	.o_bank_one_tally(o_bank_one_tally));

/* File: verification/tpc_tacho_model.sv */
// Tachogenerator pulse source for the capture bench
`timescale 1ns/1ps
module tpc_tacho_model (
	input  wire logic        i_clk,
	input  wire logic        i_go,
	input  wire logic [15:0] i_gap,
	output logic             o_tacho,
	output logic             o_busy
);
	logic [15:0] cnt_r = 16'h0000;
	// A request gives gap clocks high, then four low
	always_ff @(posedge i_clk) begin
		if (i_go) begin
			cnt_r <= i_gap + 16'h0004;
		end else if (cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end
	end
	// Four low clocks so the synchroniser cannot miss the edge
	assign o_tacho = !(cnt_r != 16'h0000 && cnt_r <= 16'h0004);
	assign o_busy  = (cnt_r != 16'h0000);
endmodule
